// file: design/rsw_pkg.sv
/*
  Shared constants, output variants and conversion functions for the reset supervisor
  and its processor-side partner.
  Assumes a 200 MHz system clock on both ends.
*/
package rsw_pkg;

  // output stage of the supervisor
  typedef enum {
    RSW_PUSH_LOW,
    RSW_PUSH_HIGH,
    RSW_PUSH_BOTH,
    RSW_OPEN_DRAIN,
    RSW_BIDIR
  } rsw_mode_t;

  localparam int CLOCK_MHZ         = 200;
  localparam int NS_PER_US         = 1000;
  // manual input glitches up to this width are rejected
  localparam int MR_GLITCH_NS      = 100;
  // one-shot that limits the active pullup
  localparam int PULLUP_SHOT_NS    = 2000;
  // internal service of an open watchdog input, as a fraction of the period
  localparam int FLOAT_NUM         = 7;
  localparam int FLOAT_DEN         = 8;
  // processor reset handshake, in processor external-clock cycles
  localparam int HOST_LOW_EXT_CYC  = 4;
  localparam int HOST_WAIT_EXT_CYC = 2;
  // power-on values of the synchronised pins
  localparam logic [6:0] SYNC_RST  = 7'h72;

  // least time: round up, never below one cycle
  function automatic int ns_to_cyc_up(input int ns);
    int c;
    c = (ns * CLOCK_MHZ + NS_PER_US - 1) / NS_PER_US;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cyc_up

  // longest time: round down, never below one cycle
  function automatic int ns_to_cyc_dn(input int ns);
    int c;
    c = (ns * CLOCK_MHZ) / NS_PER_US;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cyc_dn

  localparam int MR_GLITCH_CYC   = ns_to_cyc_up(MR_GLITCH_NS);
  localparam int PULLUP_SHOT_CYC = ns_to_cyc_dn(PULLUP_SHOT_NS);

endpackage : rsw_pkg

// file: design/rsw_if.sv
/*
  Reset line and watchdog wire between supervisor and processor.
  Resolves the shared reset line from the drivers; the two line comparators are
  driven by the environment (a model of the analog rise) through modport env.
*/
`timescale 1ns/10ps
interface rsw_if;
  logic dev_o;
  logic dev_oe;
  logic dev_hi;
  logic dev_act_pu;
  logic dev_pas_pu;
  logic host_sink;
  logic wdi_o;
  logic wdi_oe;
  logic arm_above;
  logic hi_above;
  logic line_n;
  logic watchdog_toggle_in;
  logic wdi_open;

  // any low driver wins; otherwise a pullup or the push/pull stage holds it high
  assign line_n   = ~((dev_oe & ~dev_o) | host_sink);
  // an undriven watchdog pin reads low
  assign watchdog_toggle_in      = wdi_oe & wdi_o;
  assign wdi_open = ~wdi_oe;

  modport dev (
    output dev_o, dev_oe, dev_hi, dev_act_pu, dev_pas_pu,
    input  line_n, watchdog_toggle_in, wdi_open, arm_above, hi_above
  );
  modport host (
    output host_sink, wdi_o, wdi_oe,
    input  line_n, dev_hi
  );
  modport env (
    output arm_above, hi_above,
    input  dev_o, dev_oe, dev_hi, dev_act_pu, dev_pas_pu, host_sink, wdi_o, wdi_oe,
    input  line_n, watchdog_toggle_in, wdi_open
  );
endinterface : rsw_if

// file: design/rsw_supervisor.sv
/*
  Reset supervisor with watchdog: merges supply-low, manual reset and watchdog expiry,
  stretches reset by the hold time and drives the selected output stage, including the
  bidirectional line with transition-edge flip-flop and one-shot active pullup.
  Assumes every pin input is asynchronous to CLOCK and that the comparator levels of
  the shared line arrive through the interface.
*/
`timescale 1ns/10ps

// Functional notes
// - reset on supply low, manual low, watchdog expiry
// - hold reset full timeout after each source
// - low, high or both outputs; high inverts low
// - other parties may pull shared line low
// - processor drives line low four cycles, waits two
// - processor judges cause from sampled line
// - line below arm level sets edge flip-flop
// - active pullup from arm level until high/one-shot
// - pullup sequence runs for every reset source
// - passive pullup off while asserting reset itself
// - open drain only sinks, never drives high
// - manual low asserts; timeout after release
// - reject short manual reset glitches
// - processor toggles watchdog within each period
// - watchdog clears on reset and any edge
// - watchdog held clear in reset, restarts at zero
// - open watchdog input serviced every 7/8 period
module rsw_supervisor #(
  parameter rsw_pkg::rsw_mode_t MODE           = rsw_pkg::RSW_BIDIR,
  parameter int                 RESET_HOLD_NS  = 20000,
  parameter int                 WDOG_PERIOD_NS = 100000,
  parameter bit                 WDOG_PRESENT   = 1'b1,
  parameter bit                 MANUAL_PRESENT = 1'b1
) (
  input  wire logic CLOCK,
  input  wire logic RST_N,
  input  wire logic SUPPLY_LOW,
  input  wire logic MANUAL_RESET_N,
  output logic      RESET_ACTIVE,
  rsw_if.dev        LINK
);

  localparam int HOLD_CYC  = rsw_pkg::ns_to_cyc_up(RESET_HOLD_NS);
  localparam int WD_CYC    = rsw_pkg::ns_to_cyc_dn(WDOG_PERIOD_NS);
  localparam int FLOAT_CYC = WD_CYC * rsw_pkg::FLOAT_NUM / rsw_pkg::FLOAT_DEN;
  localparam int CW        = $clog2(HOLD_CYC + WD_CYC + 2);
  localparam int MW        = $clog2(rsw_pkg::MR_GLITCH_CYC + 2);
  localparam int SW        = $clog2(rsw_pkg::PULLUP_SHOT_CYC + 2);
  localparam bit BIDIR     = (MODE == rsw_pkg::RSW_BIDIR);

  typedef enum {
    PU_IDLE,
    PU_ARMED,
    PU_ON
  } rsw_pu_t;

  // two-stage synchronisers for every pin
  logic [6:0] sync1;
  logic [6:0] sync2;
  logic [6:0] raw;

  assign raw = {LINK.hi_above, LINK.arm_above, LINK.line_n, LINK.wdi_open, LINK.watchdog_toggle_in,
                MANUAL_RESET_N, SUPPLY_LOW};

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      sync1 <= rsw_pkg::SYNC_RST;
      sync2 <= rsw_pkg::SYNC_RST;
    end else begin
      sync1 <= raw;
      sync2 <= sync1;
    end
  end

  logic s_supply_low;
  logic s_mr_n;
  logic s_wdi;
  logic s_wdi_open;
  logic s_line_n;
  logic s_arm;
  logic s_hi;

  assign s_supply_low = sync2[0];
  assign s_mr_n       = sync2[1] | ~MANUAL_PRESENT;
  assign s_wdi        = sync2[2];
  assign s_wdi_open   = sync2[3];
  assign s_line_n     = sync2[4];
  assign s_arm        = sync2[5];
  assign s_hi         = sync2[6];

  // state
  logic          asserted;
  logic [CW-1:0] hold_cnt;
  logic [MW-1:0] mr_cnt;
  logic          mr_active;
  logic [1:0]    wdi_d;
  logic [CW-1:0] wd_cnt;
  rsw_pu_t       pu_state;
  logic [SW-1:0] shot_cnt;

  logic          next_asserted;
  logic [CW-1:0] next_hold_cnt;
  logic [MW-1:0] next_mr_cnt;
  logic          next_mr_active;
  logic [CW-1:0] next_wd_cnt;
  rsw_pu_t       next_pu_state;
  logic [SW-1:0] next_shot_cnt;

  logic wdi_edge;
  logic float_clear;
  logic wd_clear;
  logic wd_fire;
  logic src;

  // manual input: low must outlast the glitch window before it counts
  always_comb begin
    next_mr_cnt    = mr_cnt;
    next_mr_active = mr_active;
    if (s_mr_n) begin
      next_mr_cnt    = '0;
      next_mr_active = 1'b0;
    end else if (mr_cnt == MW'(rsw_pkg::MR_GLITCH_CYC)) begin
      next_mr_active = 1'b1;
    end else begin
      next_mr_cnt = mr_cnt + MW'(1);
    end
  end

  // watchdog, sampled every 5 ns, so 50 ns pulses give two edges;
  // entering or leaving three-state counts too, else a re-driven pin
  // could meet a counter already near expiry
  assign wdi_edge    = |({s_wdi_open, s_wdi} ^ wdi_d);
  assign float_clear = s_wdi_open & (wd_cnt == CW'(FLOAT_CYC - 1));
  // a foreign pull of the shared line is a reset as well
  assign wd_clear    = asserted | (BIDIR & ~s_line_n) | wdi_edge | float_clear;
  assign wd_fire     = WDOG_PRESENT & ~wd_clear & (wd_cnt == CW'(WD_CYC - 1));

  always_comb begin
    next_wd_cnt = wd_cnt + CW'(1);
    if (wd_clear | wd_fire) begin
      next_wd_cnt = '0;
    end
  end

  // reset core: any source restarts the hold count
  assign src = s_supply_low | mr_active | wd_fire;

  always_comb begin
    next_asserted = asserted;
    next_hold_cnt = hold_cnt;
    if (src) begin
      next_asserted = 1'b1;
      next_hold_cnt = '0;
    end else if (asserted) begin
      if (hold_cnt == CW'(HOLD_CYC - 1)) begin
        next_asserted = 1'b0;
        next_hold_cnt = '0;
      end else begin
        next_hold_cnt = hold_cnt + CW'(1);
      end
    end
  end

  // active pullup: armed by a low line from any source, fired on release
  always_comb begin
    next_pu_state = pu_state;
    next_shot_cnt = shot_cnt;
    unique case (pu_state)
      PU_IDLE: begin
        if (!s_arm) begin
          next_pu_state = PU_ARMED;
        end
      end
      PU_ARMED: begin
        if (s_arm && s_hi) begin
          next_pu_state = PU_IDLE;
        end else if (s_arm && !asserted) begin
          next_pu_state = PU_ON;
          next_shot_cnt = '0;
        end
      end
      PU_ON: begin
        if (s_hi || shot_cnt == SW'(rsw_pkg::PULLUP_SHOT_CYC - 1)) begin
          next_pu_state = PU_IDLE;
        end else if (!s_arm || asserted) begin
          // own reset pulls the line low again: never fight the sink
          next_pu_state = PU_ARMED;
        end else begin
          next_shot_cnt = shot_cnt + SW'(1);
        end
      end
    endcase
  end

  // power-up counts as a reset source
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      asserted  <= 1'b1;
      hold_cnt  <= '0;
      mr_cnt    <= '0;
      mr_active <= 1'b0;
      wdi_d     <= '0;
      wd_cnt    <= '0;
      pu_state  <= PU_IDLE;
      shot_cnt  <= '0;
    end else begin
      asserted  <= next_asserted;
      hold_cnt  <= next_hold_cnt;
      mr_cnt    <= next_mr_cnt;
      mr_active <= next_mr_active;
      wdi_d     <= {s_wdi_open, s_wdi};
      wd_cnt    <= next_wd_cnt;
      pu_state  <= BIDIR ? next_pu_state : PU_IDLE;
      shot_cnt  <= next_shot_cnt;
    end
  end

  // output stage
  logic push_low;
  logic has_high;

  assign push_low = (MODE == rsw_pkg::RSW_PUSH_LOW) | (MODE == rsw_pkg::RSW_PUSH_BOTH);
  assign has_high = (MODE == rsw_pkg::RSW_PUSH_HIGH) | (MODE == rsw_pkg::RSW_PUSH_BOTH);

  assign RESET_ACTIVE    = asserted;
  assign LINK.dev_o      = ~asserted;
  // open drain and bidirectional only sink
  assign LINK.dev_oe     = push_low ? 1'b1 : (asserted & (MODE != rsw_pkg::RSW_PUSH_HIGH));
  assign LINK.dev_hi     = has_high & asserted;
  assign LINK.dev_act_pu = BIDIR & (pu_state == PU_ON) & ~asserted;
  // saves supply current while the line is held low anyway
  assign LINK.dev_pas_pu = BIDIR & ~asserted;

endmodule : rsw_supervisor

// file: design/rsw_host.sv
/*
  Processor side of the supervisor link: bidirectional reset handshake with cause
  detection, and the watchdog toggle output.
  Assumes user requests come from logic on CLOCK; the reset line is asynchronous.
*/
`timescale 1ns/10ps
module rsw_host #(
  parameter int EXT_DIV = 50
) (
  input  wire logic CLOCK,
  input  wire logic RST_N,
  input  wire logic SELF_RESET_REQ,
  input  wire logic WDOG_KICK,
  input  wire logic WDOG_RELEASE,
  output logic      IN_RESET,
  output logic      CAUSE_EXTERNAL,
  output logic      CAUSE_SELF,
  rsw_if.host       LINK
);

  localparam int LOW_CYC  = rsw_pkg::HOST_LOW_EXT_CYC * EXT_DIV;
  localparam int WAIT_CYC = rsw_pkg::HOST_WAIT_EXT_CYC * EXT_DIV;
  localparam int HW       = $clog2(LOW_CYC + WAIT_CYC + 2);

  typedef enum {
    H_RUN,
    H_DRIVE,
    H_WAIT,
    H_HELD
  } rsw_host_t;

  logic          line1;
  logic          line2;
  rsw_host_t     state;
  rsw_host_t     next_state;
  logic [HW-1:0] cnt;
  logic [HW-1:0] next_cnt;
  logic          next_ext;
  logic          next_self;
  logic          wdi_lvl;

  always_comb begin
    next_state = state;
    next_cnt   = cnt + HW'(1);
    next_ext   = 1'b0;
    next_self  = 1'b0;
    unique case (state)
      H_RUN: begin
        next_cnt = '0;
        // every reset, own or foreign, starts with our own low drive
        if (SELF_RESET_REQ || !line2) begin
          next_state = H_DRIVE;
        end
      end
      H_DRIVE: begin
        if (cnt == HW'(LOW_CYC - 1)) begin
          next_state = H_WAIT;
          next_cnt   = '0;
        end
      end
      H_WAIT: begin
        if (cnt == HW'(WAIT_CYC - 1)) begin
          next_cnt = '0;
          if (!line2) begin
            next_state = H_HELD;
          end else begin
            next_state = H_RUN;
            next_self  = 1'b1;
          end
        end
      end
      H_HELD: begin
        next_cnt = '0;
        if (line2) begin
          next_state = H_RUN;
          next_ext   = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      line1          <= 1'b1;
      line2          <= 1'b1;
      state          <= H_RUN;
      cnt            <= '0;
      CAUSE_EXTERNAL <= 1'b0;
      CAUSE_SELF     <= 1'b0;
      wdi_lvl        <= 1'b0;
    end else begin
      line1          <= LINK.line_n;
      line2          <= line1;
      state          <= next_state;
      cnt            <= next_cnt;
      CAUSE_EXTERNAL <= next_ext;
      CAUSE_SELF     <= next_self;
      wdi_lvl        <= wdi_lvl ^ WDOG_KICK;
    end
  end

  assign IN_RESET       = (state != H_RUN);
  assign LINK.host_sink = (state == H_DRIVE);
  assign LINK.wdi_o     = wdi_lvl;
  assign LINK.wdi_oe    = ~WDOG_RELEASE;

endmodule : rsw_host

// file: testbench/rsw_link_chk.sv
/*
  Checker for the supervisor link, fed with the interface signals as plain inputs.
  Assumes one clock domain, RST_N async active low, comparators driven by the bench.
*/
`timescale 1ns/10ps
module rsw_link_chk #(
  parameter int HOLD_CYC = 40,
  parameter int WD_CYC   = 200,
  parameter int LOW_CYC  = 16
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic dev_o,
  input wire logic dev_oe,
  input wire logic dev_act_pu,
  input wire logic dev_pas_pu,
  input wire logic host_sink,
  input wire logic line_n,
  input wire logic watchdog_toggle_in,
  input wire logic wdi_open,
  input wire logic arm_above,
  input wire logic hi_above
);
  localparam int PU_CYC = rsw_pkg::PULLUP_SHOT_CYC;
  int   wcnt;
  int   lcnt;
  int   scnt;
  int   pcnt;
  logic wprev;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  // counts ahead of the device's sync flops, hence the slack on the watchdog bound
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      wcnt  <= 0;
      lcnt  <= 0;
      scnt  <= 0;
      pcnt  <= 0;
      wprev <= 1'b0;
    end else begin
      wprev <= watchdog_toggle_in;
      wcnt  <= (!dev_o || watchdog_toggle_in != wprev || wdi_open || !line_n) ? 0 : wcnt + 1;
      lcnt  <= dev_o ? 0 : lcnt + 1;
      scnt  <= host_sink ? scnt + 1 : 0;
      pcnt  <= dev_act_pu ? pcnt + 1 : 0;
    end
  end

  property p_pas_off; !dev_o && dev_oe |-> !dev_pas_pu; endproperty
  property p_pu_dev; dev_act_pu |-> dev_o; endproperty
  property p_pu_on;
    (!arm_above)[*4] ##1 (arm_above && !hi_above && dev_o)[*3] |=> dev_act_pu;
  endproperty
  property p_pu_hi; hi_above[*4] |-> !dev_act_pu; endproperty
  property p_pu_shot; pcnt <= PU_CYC + 1; endproperty
  property p_wd_fire; wcnt <= WD_CYC + 6; endproperty
  property p_hold; $rose(dev_o) |-> lcnt >= HOLD_CYC; endproperty
  property p_sink_len; $fell(host_sink) |-> scnt == LOW_CYC; endproperty
  property p_sink_wait; $fell(host_sink) |-> !host_sink[*8]; endproperty

  a_pas_off: assert property (p_pas_off) else $error("passive pullup on in reset");
  a_pu_dev: assert property (p_pu_dev) else $error("active pullup while asserting");
  a_pu_on: assert property (p_pu_on) else $error("active pullup not started");
  a_pu_hi: assert property (p_pu_hi) else $error("active pullup stays on when high");
  a_pu_shot: assert property (p_pu_shot) else $error("active pullup too long");
  a_wd_fire: assert property (p_wd_fire) else $error("watchdog did not fire");
  a_hold: assert property (p_hold) else $error("reset shorter than hold time");
  a_sink_len: assert property (p_sink_len) else $error("host low drive length");
  a_sink_wait: assert property (p_sink_wait) else $error("host wait before sample");

  c_pu: cover property ($rose(dev_act_pu));
  c_sink: cover property ($fell(host_sink));
  c_rel: cover property ($rose(dev_o));
endmodule : rsw_link_chk

// file: testbench/testbench.sv
/*
  Testbench: supervisor and processor side joined by the link interface.
  Assumes shortened hold (40 cycles), watchdog (200) and processor clock divider (4).
*/
`timescale 1ns/10ps
module testbench;
  localparam int HOLD = 40;
  localparam int WD   = 200;
  logic CLOCK = 1'b0;
  logic RST_N = 1'b0;
  logic SUPPLY_LOW = 1'b0;
  logic MANUAL_RESET_N = 1'b1;
  logic SELF_RESET_REQ = 1'b0;
  logic WDOG_KICK = 1'b0;
  logic WDOG_RELEASE = 1'b0;
  logic RESET_ACTIVE, IN_RESET, CAUSE_EXTERNAL, CAUSE_SELF;
  logic [4:0] dly = 5'h00;
  logic kick_en = 1'b1;
  logic ra_seen = 1'b0;
  logic pu_seen = 1'b0;
  int   kcnt = 0;
  int   n_self = 0;
  int   n_ext = 0;
  int   failures = 0;
  int   n_tests = 0;
  int   n;
  int   e0;
  int   pu_cnt = 0;
  logic hi_block = 1'b0;

  rsw_if bus ();
  rsw_supervisor #(.RESET_HOLD_NS(200), .WDOG_PERIOD_NS(1000)) i_rsw_supervisor (
    .CLOCK(CLOCK), .RST_N(RST_N), .SUPPLY_LOW(SUPPLY_LOW),
    .MANUAL_RESET_N(MANUAL_RESET_N), .RESET_ACTIVE(RESET_ACTIVE), .LINK(bus.dev));
  rsw_host #(.EXT_DIV(4)) i_rsw_host (
    .CLOCK(CLOCK), .RST_N(RST_N), .SELF_RESET_REQ(SELF_RESET_REQ), .WDOG_KICK(WDOG_KICK),
    .WDOG_RELEASE(WDOG_RELEASE), .IN_RESET(IN_RESET), .CAUSE_EXTERNAL(CAUSE_EXTERNAL),
    .CAUSE_SELF(CAUSE_SELF), .LINK(bus.host));
  rsw_link_chk #(.HOLD_CYC(HOLD), .WD_CYC(WD), .LOW_CYC(16)) i_rsw_link_chk (
    .CLOCK(CLOCK), .RST_N(RST_N), .dev_o(bus.dev_o), .dev_oe(bus.dev_oe),
    .dev_act_pu(bus.dev_act_pu), .dev_pas_pu(bus.dev_pas_pu), .host_sink(bus.host_sink),
    .line_n(bus.line_n), .watchdog_toggle_in(bus.watchdog_toggle_in), .wdi_open(bus.wdi_open),
    .arm_above(bus.arm_above), .hi_above(bus.hi_above));

  // variants without a processor: line idle, watchdog pin left open
  rsw_if bus_od ();
  rsw_if bus_pb ();
  assign bus_od.host_sink = 1'b0;
  assign bus_od.wdi_o     = 1'b0;
  assign bus_od.wdi_oe    = 1'b0;
  assign bus_od.arm_above = 1'b0;
  assign bus_od.hi_above  = 1'b0;
  assign bus_pb.host_sink = 1'b0;
  assign bus_pb.wdi_o     = 1'b0;
  assign bus_pb.wdi_oe    = 1'b0;
  assign bus_pb.arm_above = 1'b0;
  assign bus_pb.hi_above  = 1'b0;
  rsw_supervisor #(.MODE(rsw_pkg::RSW_OPEN_DRAIN), .RESET_HOLD_NS(200),
    .WDOG_PERIOD_NS(1000)) i_rsw_supervisor_od (
    .CLOCK(CLOCK), .RST_N(RST_N), .SUPPLY_LOW(SUPPLY_LOW),
    .MANUAL_RESET_N(MANUAL_RESET_N), .RESET_ACTIVE(), .LINK(bus_od.dev));
  rsw_supervisor #(.MODE(rsw_pkg::RSW_PUSH_BOTH), .RESET_HOLD_NS(200),
    .WDOG_PERIOD_NS(1000)) i_rsw_supervisor_pb (
    .CLOCK(CLOCK), .RST_N(RST_N), .SUPPLY_LOW(SUPPLY_LOW),
    .MANUAL_RESET_N(MANUAL_RESET_N), .RESET_ACTIVE(), .LINK(bus_pb.dev));

  always #2.5 CLOCK = ~CLOCK;

  // slow rise of the line: arm level after two samples high, 0.85 level after six
  // hi_block keeps the 0.85 level away so only the one-shot can end the pullup
  always @(negedge CLOCK) begin
    dly <= {dly[3:0], bus.line_n};
    bus.arm_above <= bus.line_n & dly[0];
    bus.hi_above <= bus.line_n & (&dly) & ~hi_block;
    kcnt <= kcnt + 1;
    WDOG_KICK <= kick_en && (kcnt % 50 == 0);
  end

  always @(posedge CLOCK) begin
    if (RESET_ACTIVE === 1'b1) ra_seen = 1'b1;
    if (bus.dev_act_pu === 1'b1) begin
      pu_seen = 1'b1;
      pu_cnt++;
    end
    if (CAUSE_SELF === 1'b1) n_self++;
    if (CAUSE_EXTERNAL === 1'b1) n_ext++;
  end

  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task wait_rel();
    n = 0;
    while (RESET_ACTIVE !== 1'b0 && n < 3000) begin
      @(negedge CLOCK);
      n++;
    end
    check("release within limit", n < 3000, 1'b1);
  endtask : wait_rel

  task settle();
    wait_rel();
    repeat (200) begin
      @(negedge CLOCK);
      if (IN_RESET === 1'b0 && RESET_ACTIVE === 1'b0) break;
    end
    check("host back in run", IN_RESET, 1'b0);
    repeat (20) @(negedge CLOCK);
    ra_seen = 1'b0;
    pu_seen = 1'b0;
  endtask : settle

  task t_supply();
    e0 = n_ext;
    SUPPLY_LOW = 1'b1;
    repeat (4) @(negedge CLOCK);
    check("reset on supply low", RESET_ACTIVE, 1'b1);
    check("line low in reset", bus.line_n, 1'b0);
    check("open drain sinks in reset", bus_od.dev_oe, 1'b1);
    check("high output in reset", bus_pb.dev_hi, 1'b1);
    repeat (20) @(negedge CLOCK);
    SUPPLY_LOW = 1'b0;
    repeat (20) @(negedge CLOCK);
    SUPPLY_LOW = 1'b1;
    @(negedge CLOCK);
    SUPPLY_LOW = 1'b0;
    wait_rel();
    check("hold restarted", (n >= HOLD) && (n <= HOLD + 4), 1'b1);
    settle();
    check("open drain never drives", bus_od.dev_oe, 1'b0);
    check("high output released", bus_pb.dev_hi, 1'b0);
    check("push-pull drives high", bus_pb.line_n, 1'b1);
    check("external cause", n_ext, e0 + 1);
  endtask : t_supply

  task t_manual();
    MANUAL_RESET_N = 1'b0;
    repeat (15) @(negedge CLOCK);
    MANUAL_RESET_N = 1'b1;
    repeat (30) @(negedge CLOCK);
    check("glitch ignored", ra_seen, 1'b0);
    MANUAL_RESET_N = 1'b0;
    repeat (40) @(negedge CLOCK);
    check("manual asserts", RESET_ACTIVE, 1'b1);
    MANUAL_RESET_N = 1'b1;
    wait_rel();
    check("manual hold", (n >= HOLD) && (n <= HOLD + 4), 1'b1);
    settle();
  endtask : t_manual

  task t_watchdog();
    repeat (1000) @(negedge CLOCK);
    check("serviced watchdog quiet", ra_seen, 1'b0);
    kick_en = 1'b0;
    for (n = 0; n < 400 && RESET_ACTIVE !== 1'b1; n++) @(negedge CLOCK);
    check("watchdog expiry", (n >= WD - 52) && (n <= WD + 6), 1'b1);
    wait_rel();
    // no kicks after release: expiry measured from a cleared counter
    for (n = 0; n < 400 && RESET_ACTIVE !== 1'b1; n++) @(negedge CLOCK);
    check("restart from zero", (n >= WD) && (n <= WD + 8), 1'b1);
    kick_en = 1'b1;
    settle();
  endtask : t_watchdog

  task t_float();
    kick_en = 1'b0;
    WDOG_RELEASE = 1'b1;
    repeat (3 * WD) @(negedge CLOCK);
    check("open input no reset", ra_seen, 1'b0);
    kick_en = 1'b1;
    WDOG_RELEASE = 1'b0;
    settle();
  endtask : t_float

  task t_self();
    e0 = n_self;
    SELF_RESET_REQ = 1'b1;
    @(negedge CLOCK);
    SELF_RESET_REQ = 1'b0;
    for (n = 0; n < 300 && IN_RESET !== 1'b0; n++) @(negedge CLOCK);
    repeat (10) @(negedge CLOCK);
    check("self cause", n_self, e0 + 1);
    check("foreign low not stretched", ra_seen, 1'b0);
    check("pullup after foreign low", pu_seen, 1'b1);
    settle();
  endtask : t_self

  task t_shot();
    hi_block = 1'b1;
    pu_cnt = 0;
    SELF_RESET_REQ = 1'b1;
    @(negedge CLOCK);
    SELF_RESET_REQ = 1'b0;
    repeat (500) @(negedge CLOCK);
    check("pullup one-shot length", pu_cnt, rsw_pkg::PULLUP_SHOT_CYC);
    hi_block = 1'b0;
    settle();
  endtask : t_shot

  task summarize();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize

  initial begin
    repeat (3) @(negedge CLOCK);
    RST_N = 1'b1;
    wait_rel();
    check("power-up hold", (n >= HOLD) && (n <= HOLD + 4), 1'b1);
    settle();
    t_supply();
    t_manual();
    t_watchdog();
    t_float();
    t_self();
    t_shot();
    summarize();
  end

  // whole run needs well under 8000 cycles
  initial begin
    #100000;
    $display("Error timeout expected tests done seen still running");
    failures++;
    summarize();
  end
endmodule : testbench
